// *** core/cdsp_defines.svh ***
// constants for the sync and power control register bank and its host
`ifndef CDSP_DEFINES_SVH
`define CDSP_DEFINES_SVH
`define CDSP_ADDR_SYNC_CTRL   8'h58
`define CDSP_ADDR_UNUSED      8'h59
`define CDSP_ADDR_UPDATE      8'h5A
`define CDSP_BIT_DET_EN       0
`define CDSP_BIT_DET_SEL      1
`define CDSP_BIT_SOFT_SYNC    2
`define CDSP_BIT_REF_PD       3
`define CDSP_BIT_SYNC_PD      4
`define CDSP_FUNC_LSB         5
`define CDSP_FUNC_MSB         6
`define CDSP_BIT_UPDATE       0
`define CDSP_SYNC_CTRL_MASK   8'h7F
`define CDSP_SYNC_CTRL_RESET  8'h00
`define CDSP_FUNC_RESET_IN    2'h0
`define CDSP_FUNC_SYNC_IN     2'h1
`define CDSP_FUNC_TEST        2'h2
`define CDSP_FUNC_PD_IN       2'h3
`define CDSP_HOST_CTRL        4'h0
`define CDSP_HOST_ADDR        4'h1
`define CDSP_HOST_WDATA       4'h2
`define CDSP_HOST_RDATA       4'h3
`define CDSP_HOST_STATUS      4'h4
`define CDSP_HOST_IRQ_CLR     4'h5
`define CDSP_HOST_IRQ_EN      4'h6
`define CDSP_HOST_CTRL_WRITE  0
`define CDSP_HOST_CTRL_READ   1
`define CDSP_HOST_CTRL_UPDATE 2
`define CDSP_IRQ_DONE         0
`define CDSP_IRQ_TEST_REFUSED 1
`define CDSP_IRQ_SYNC_EVENT   2
`endif

// *** core/cdsp_pkg.sv ***
// types for the host end of the sync and power control link
package cdsp_pkg;
  typedef enum logic [2:0] {
    CDSP_IDLE = 3'b001,
    CDSP_WAIT = 3'b010,
    CDSP_READ = 3'b100
  } cdsp_host_state_t;
endpackage

// *** core/cdsp_if.sv ***
// serial control port link between host controller and device bank
`timescale 1ns/1ps
`default_nettype none
interface cdsp_if;
  logic       sclk;
  logic       wr_en;
  logic       rd_en;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport device (input sclk, input wr_en, input rd_en, input addr,
                  input wdata, output rdata);
  modport host (output sclk, output wr_en, output rd_en, output addr,
                output wdata, input rdata);
endinterface
`default_nettype wire

// *** core/cdsp_device.sv ***
// device end: buffered and active sync/function and update registers
//
// Design decision made here: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "cdsp_defines.svh"
// How it works
// - soft sync holds outputs; falling edge syncs
// - bit 3 powers down distribution references
// - bit 4 powers down sync circuitry
// - two-bit field picks multi-function pin role
// - update write copies buffer on next edge
// - update bit clears itself after transfer
// - registers volatile; reset restores defaults
// - bypassed divider has its logic powered down
// - fine delay powered down when not selected
// - pll, outputs, distribution powered down independently
// - power-down keeps register contents intact
// - after power-down, host must resync outputs
// - bit 0 enables sync-detect monitor
// - bit 1 selects sync-detect threshold
// - ignore-sync outputs skip chip-level sync
module cdsp_device #(
  parameter int N_OUT = 5
) (
  input  wire logic             ref_clk,
  input  wire logic             rst,
  cdsp_if.device                port,
  input  wire logic [N_OUT-1:0] bypass_div,
  input  wire logic [N_OUT-1:0] ignore_sync,
  input  wire logic             delay_sel,
  input  wire logic             pll_pd_req,
  input  wire logic [N_OUT-1:0] out_pd_req,
  input  wire logic             dist_pd_req,
  input  wire logic             func_pin,
  output var  logic             hold_outputs,
  output var  logic [N_OUT-1:0] sync_pulse,
  output var  logic             ref_pd,
  output var  logic             sync_pd,
  output var  logic             detect_en,
  output var  logic             detect_fine,
  output var  logic             chip_reset,
  output var  logic             pin_pd,
  output var  logic [N_OUT-1:0] div_pd,
  output var  logic             delay_pd,
  output var  logic             pll_pd,
  output var  logic [N_OUT-1:0] out_pd,
  output var  logic             dist_pd,
  output var  logic             align_lost
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0]       buf_reg;
    logic [7:0]       act_reg;
    logic [7:0]       rdata_reg;
    logic [1:0]       pin_sync;
    logic             pin_prev;
    logic             hold;
    logic [N_OUT-1:0] sync;
    logic [N_OUT-1:0] div_pd;
    logic             delay_pd;
    logic             pll_pd;
    logic [N_OUT-1:0] out_pd;
    logic             dist_pd;
    logic             reset_out;
    logic             pin_pd;
    logic             lost;
  } cdsp_dev_state_t;

  cdsp_dev_state_t s_reg;
  cdsp_dev_state_t s_next;
  logic [1:0]      func;
  logic            soft_fall;
  logic            pin_fall;
  logic            any_pd;
  logic            wr_sync_hit;
  logic            wr_update_hit;
  logic            rd_sync_hit;
  logic            pin_low;
  logic            reset_mode;
  logic            realign_mode;
  logic            pd_mode;
  logic            chip_sync;
  logic [N_OUT-1:0] out_sync;

  // ----------------------------------------------------------------
  // link decode
  // ----------------------------------------------------------------
  // other addresses answer zero on the edge after the read
  assign wr_sync_hit   = port.wr_en && (port.addr == `CDSP_ADDR_SYNC_CTRL);
  assign wr_update_hit = port.wr_en && (port.addr == `CDSP_ADDR_UPDATE) &&
                         port.wdata[`CDSP_BIT_UPDATE];
  assign rd_sync_hit   = port.rd_en && (port.addr == `CDSP_ADDR_SYNC_CTRL);

  // ----------------------------------------------------------------
  // pin role decode
  // ----------------------------------------------------------------
  // role follows the active copy, so a new code waits for an update
  assign func         = s_reg.act_reg[`CDSP_FUNC_MSB:`CDSP_FUNC_LSB];
  assign pin_low      = !s_reg.pin_sync[1];
  assign reset_mode   = (func == `CDSP_FUNC_RESET_IN);
  assign realign_mode = (func == `CDSP_FUNC_SYNC_IN);
  assign pd_mode      = (func == `CDSP_FUNC_PD_IN);

  // ----------------------------------------------------------------
  // sync generation
  // ----------------------------------------------------------------
  // soft bit falling on the update edge is a sync
  assign soft_fall = s_reg.act_reg[`CDSP_BIT_SOFT_SYNC] && wr_update_hit &&
                     !s_reg.buf_reg[`CDSP_BIT_SOFT_SYNC];
  assign pin_fall  = realign_mode && s_reg.pin_prev && pin_low;
  assign chip_sync = (soft_fall || pin_fall) &&
                     !s_reg.act_reg[`CDSP_BIT_SYNC_PD];
  // one chip-level sync fans out; each output may opt out
  for (genvar i = 0; i < N_OUT; i++) begin : g_out
    assign out_sync[i] = chip_sync && !ignore_sync[i];
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    s_next = s_reg;
    // --------------------------------------------------------------
    // link writes and reads
    // --------------------------------------------------------------
    // buffered writes; unused bits and 0x59 drop data
    if (wr_sync_hit) begin
      s_next.buf_reg = port.wdata & `CDSP_SYNC_CTRL_MASK;
    end
    // update copies the buffer; the strobe is never stored
    if (wr_update_hit) begin
      s_next.act_reg = s_reg.buf_reg;
    end
    s_next.rdata_reg = 8'h00;
    if (rd_sync_hit) begin
      s_next.rdata_reg = s_reg.buf_reg;
    end
    // --------------------------------------------------------------
    // pin role and sync
    // --------------------------------------------------------------
    // pin sampled through two flops before use
    s_next.pin_sync = {s_reg.pin_sync[0], func_pin};
    s_next.pin_prev = s_reg.pin_sync[1];
    // soft bit is the inverse of the low-active realign pin
    s_next.hold = s_next.act_reg[`CDSP_BIT_SOFT_SYNC] ||
                  (realign_mode && pin_low);
    s_next.sync = out_sync;
    s_next.reset_out = reset_mode && pin_low;
    s_next.pin_pd = pd_mode && pin_low;
    // --------------------------------------------------------------
    // power gating
    // --------------------------------------------------------------
    // power-down gates only; config stays in act_reg
    s_next.div_pd = bypass_div;
    s_next.delay_pd = !delay_sel;
    s_next.pll_pd = pll_pd_req;
    s_next.out_pd = out_pd_req;
    s_next.dist_pd = dist_pd_req;
    any_pd = pll_pd_req || dist_pd_req || s_next.pin_pd ||
             (|out_pd_req) || s_next.act_reg[`CDSP_BIT_REF_PD] ||
             s_next.act_reg[`CDSP_BIT_SYNC_PD];
    // alignment lost until a sync arrives
    if (any_pd) begin
      s_next.lost = 1'b1;
    end else if (|s_next.sync) begin
      s_next.lost = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // registers; reset brings back defaults
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_reg <= '0;
      // synchroniser starts at the pin's idle high level: no false event
      s_reg.pin_sync <= 2'h3;
      s_reg.pin_prev <= 1'h1;
    end else begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // every output is a flop of the state struct, never a gate
  assign port.rdata   = s_reg.rdata_reg;
  assign hold_outputs = s_reg.hold;
  assign sync_pulse   = s_reg.sync;
  assign ref_pd       = s_reg.act_reg[`CDSP_BIT_REF_PD];
  assign sync_pd      = s_reg.act_reg[`CDSP_BIT_SYNC_PD];
  assign detect_en    = s_reg.act_reg[`CDSP_BIT_DET_EN];
  assign detect_fine  = s_reg.act_reg[`CDSP_BIT_DET_SEL];
  assign chip_reset   = s_reg.reset_out;
  assign pin_pd       = s_reg.pin_pd;
  assign div_pd       = s_reg.div_pd;
  assign delay_pd     = s_reg.delay_pd;
  assign pll_pd       = s_reg.pll_pd;
  assign out_pd       = s_reg.out_pd;
  assign dist_pd      = s_reg.dist_pd;
  assign align_lost   = s_reg.lost;
endmodule
`default_nettype wire

// *** core/cdsp_host.sv ***
// host end: software register port driving the serial control link
`timescale 1ns/1ps
`default_nettype none
`include "cdsp_defines.svh"
module cdsp_host (
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic [3:0] sw_addr,
  input  wire logic [7:0] sw_wdata,
  input  wire logic       sw_wr,
  input  wire logic       sw_rd,
  output var  logic [7:0] sw_rdata,
  output var  logic       irq,
  cdsp_if.host            port
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    cdsp_pkg::cdsp_host_state_t st;
    logic [7:0] addr_reg;
    logic [7:0] wdata_reg;
    logic [7:0] rdata_reg;
    logic [7:0] sw_rdata_reg;
    logic [2:0] status_reg;
    logic [2:0] en_reg;
    logic       wr_reg;
    logic       rd_reg;
    logic       irq_reg;
    logic       rd_pend;
  } cdsp_host_s_t;

  cdsp_host_s_t s_reg;
  cdsp_host_s_t s_next;
  logic [2:0]   ev;
  logic [2:0]   clr;
  logic         test_code;

  always_comb begin
    s_next = s_reg;
    ev = 3'h0;
    clr = 3'h0;
    s_next.wr_reg = 1'b0;
    s_next.rd_reg = 1'b0;
    s_next.sw_rdata_reg = 8'h00;
    // the reserved pin code is never sent to the device
    test_code = (s_reg.addr_reg == `CDSP_ADDR_SYNC_CTRL) &&
      (s_reg.wdata_reg[`CDSP_FUNC_MSB:`CDSP_FUNC_LSB] == `CDSP_FUNC_TEST);
    if (sw_wr) begin
      unique case (sw_addr)
        `CDSP_HOST_ADDR: s_next.addr_reg = sw_wdata;
        `CDSP_HOST_WDATA: s_next.wdata_reg = sw_wdata;
        `CDSP_HOST_IRQ_CLR: clr = sw_wdata[2:0];
        `CDSP_HOST_IRQ_EN: s_next.en_reg = sw_wdata[2:0];
        default: ;
      endcase
    end
    if (sw_rd) begin
      unique case (sw_addr)
        `CDSP_HOST_ADDR: s_next.sw_rdata_reg = s_reg.addr_reg;
        `CDSP_HOST_WDATA: s_next.sw_rdata_reg = s_reg.wdata_reg;
        `CDSP_HOST_RDATA: s_next.sw_rdata_reg = s_reg.rdata_reg;
        `CDSP_HOST_STATUS: s_next.sw_rdata_reg = {5'h00, s_reg.status_reg};
        `CDSP_HOST_IRQ_EN: s_next.sw_rdata_reg = {5'h00, s_reg.en_reg};
        default: s_next.sw_rdata_reg = 8'h00;
      endcase
    end
    unique case (s_reg.st)
      cdsp_pkg::CDSP_IDLE: begin
        if (sw_wr && sw_addr == `CDSP_HOST_CTRL) begin
          if (sw_wdata[`CDSP_HOST_CTRL_WRITE]) begin
            if (test_code) begin
              ev[`CDSP_IRQ_TEST_REFUSED] = 1'b1;
            end else begin
              s_next.wr_reg = 1'b1;
              s_next.st = cdsp_pkg::CDSP_WAIT;
            end
          end else if (sw_wdata[`CDSP_HOST_CTRL_READ]) begin
            s_next.rd_reg = 1'b1;
            s_next.rd_pend = 1'b1;
            s_next.st = cdsp_pkg::CDSP_WAIT;
          end else if (sw_wdata[`CDSP_HOST_CTRL_UPDATE]) begin
            // one-shot; device self-clears, no zero write
            s_next.wr_reg = 1'b1;
            s_next.addr_reg = `CDSP_ADDR_UPDATE;
            s_next.wdata_reg = 8'h01;
            s_next.st = cdsp_pkg::CDSP_WAIT;
            // updates after a soft sync fall realign outputs
            ev[`CDSP_IRQ_SYNC_EVENT] = 1'b1;
          end
        end
      end
      cdsp_pkg::CDSP_WAIT: begin
        // read data stand one edge after the device takes the strobe
        if (s_reg.rd_pend) begin
          s_next.rd_pend = 1'b0;
          s_next.st = cdsp_pkg::CDSP_READ;
        end else begin
          ev[`CDSP_IRQ_DONE] = 1'b1;
          s_next.st = cdsp_pkg::CDSP_IDLE;
        end
      end
      cdsp_pkg::CDSP_READ: begin
        s_next.rdata_reg = port.rdata;
        ev[`CDSP_IRQ_DONE] = 1'b1;
        s_next.st = cdsp_pkg::CDSP_IDLE;
      end
      default: s_next.st = cdsp_pkg::CDSP_IDLE;
    endcase
    // set wins over clear
    s_next.status_reg = (s_reg.status_reg & ~clr) | ev;
    s_next.irq_reg = |(s_next.status_reg & s_next.en_reg);
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_reg <= '0;
      s_reg.st <= cdsp_pkg::CDSP_IDLE;
    end else begin
      s_reg <= s_next;
    end
  end

  assign sw_rdata    = s_reg.sw_rdata_reg;
  assign irq         = s_reg.irq_reg;
  assign port.sclk   = ref_clk;
  assign port.wr_en  = s_reg.wr_reg;
  assign port.rd_en  = s_reg.rd_reg;
  assign port.addr   = s_reg.addr_reg;
  assign port.wdata  = s_reg.wdata_reg;
endmodule
`default_nettype wire

// *** verification/cdsp_checker.sv ***
// concurrent checks on the link and on the device's power outputs
`timescale 1ns/1ps
`default_nettype none
module cdsp_checker (
  input wire logic       ref_clk,
  input wire logic       rst,
  input wire logic       wr_en,
  input wire logic       rd_en,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic       ref_pd,
  input wire logic       sync_pd,
  input wire logic       detect_en,
  input wire logic       detect_fine,
  input wire logic       align_lost,
  input wire logic       pll_pd_req,
  input wire logic       pll_pd,
  input wire logic       delay_sel,
  input wire logic       delay_pd
);
  // ----------------------------------------
  // buffer shadow and properties
  // ----------------------------------------
  logic [7:0] shadow_reg;
  wire  logic up = wr_en && addr == 8'h5A && wdata[0];
  // shadow is untouched on an update edge, so it still holds the copy
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      shadow_reg <= 8'h00;
    end else if (wr_en && addr == 8'h58) begin
      shadow_reg <= wdata & 8'h7F;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  AST_RD_IDLE: assert property (
    !rd_en |=> rdata == 8'h00) else $error("rdata not idle zero");
  AST_RD_RSVD: assert property (
    rd_en && addr inside {8'h59, 8'h5A} |=> rdata == 8'h00)
    else $error("reserved read not zero");
  AST_COPY_PD: assert property (
    up |=> {sync_pd, ref_pd} == shadow_reg[4:3])
    else $error("power bits not copied on update");
  AST_COPY_DET: assert property (
    up |=> {detect_fine, detect_en} == shadow_reg[1:0])
    else $error("detect bits not copied on update");
  AST_ACTIVE_HOLD: assert property (
    !up |=> $stable({sync_pd, ref_pd, detect_fine, detect_en}))
    else $error("active bits moved without update");
  AST_ALIGN_LOST: assert property (
    $rose(ref_pd) |-> ##[0:1] align_lost)
    else $error("alignment loss not flagged");
  AST_PLL_PD: assert property (
    $rose(pll_pd_req) |-> ##[0:3] pll_pd) else $error("pll not down");
  AST_DELAY_PD: assert property (
    $fell(delay_sel) |-> ##[0:3] delay_pd) else $error("delay not down");
endmodule
`default_nettype wire

// *** verification/clock_dist_sync_power_ctrl_tb.sv ***
// self-checking bench joining host and device ends over the link
`timescale 1ns/1ps
`default_nettype none
module clock_dist_sync_power_ctrl_tb;
  logic       ref_clk = 1'h0, rst = 1'h1, sw_wr = 1'h0, sw_rd = 1'h0, irq;
  logic [3:0] sw_addr = 4'h0;
  logic [7:0] sw_wdata = 8'h00, sw_rdata, rd;
  logic [4:0] bypass_div = 5'h00, ignore_sync = 5'h00, out_pd_req = 5'h00;
  logic       delay_sel = 1'h1, pll_pd_req = 1'h0, dist_pd_req = 1'h0;
  logic       func_pin = 1'h1, hold_outputs, ref_pd, sync_pd, detect_en;
  logic       detect_fine, pin_pd, delay_pd, pll_pd, dist_pd, align_lost;
  logic [4:0] sync_pulse, div_pd, out_pd, seen;
  logic       chip_reset, clr_seen = 1'h0;
  int         err_count = 0, compares = 0;
  // rows: write value, readback, {hold, fine, en, sync_pd, ref_pd}
  logic [20:0] rows [7] = '{{8'h08, 8'h08, 5'h01}, {8'h10, 8'h10, 5'h02},
    {8'h01, 8'h01, 5'h04}, {8'h02, 8'h02, 5'h08}, {8'h84, 8'h04, 5'h10},
    {8'h60, 8'h60, 5'h00}, {8'h20, 8'h20, 5'h00}};
  cdsp_if lnk ();
  cdsp_device u_cdsp_device (.ref_clk, .rst, .port(lnk), .bypass_div,
    .ignore_sync, .delay_sel, .pll_pd_req, .out_pd_req, .dist_pd_req,
    .func_pin, .hold_outputs, .sync_pulse, .ref_pd, .sync_pd, .detect_en,
    .detect_fine, .chip_reset, .pin_pd, .div_pd, .delay_pd, .pll_pd,
    .out_pd, .dist_pd, .align_lost);
  cdsp_host u_cdsp_host (.ref_clk, .rst, .sw_addr, .sw_wdata, .sw_wr,
    .sw_rd, .sw_rdata, .irq, .port(lnk));
  cdsp_checker u_cdsp_checker (.ref_clk, .rst, .wr_en(lnk.wr_en),
    .rd_en(lnk.rd_en), .addr(lnk.addr), .wdata(lnk.wdata),
    .rdata(lnk.rdata), .ref_pd, .sync_pd, .detect_en, .detect_fine,
    .align_lost, .pll_pd_req, .pll_pd, .delay_sel, .delay_pd);
  always #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) seen <= clr_seen ? 5'h00 : (seen | sync_pulse);
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic clr();
    clr_seen <= 1'h1;
    @(posedge ref_clk);
    clr_seen <= 1'h0;
  endtask
  task automatic chk(string n, logic [8:0] s, logic [8:0] e);
    compares++;
    if (s !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic swr(logic [3:0] a, logic [7:0] d);
    @(posedge ref_clk);
    sw_addr <= a;
    sw_wdata <= d;
    sw_wr <= 1'h1;
    @(posedge ref_clk);
    sw_wr <= 1'h0;
  endtask
  task automatic srd(logic [3:0] a);
    @(posedge ref_clk);
    sw_addr <= a;
    sw_rd <= 1'h1;
    @(posedge ref_clk);
    sw_rd <= 1'h0;
    @(negedge ref_clk);
    rd = sw_rdata;
  endtask
  // bounded poll of the status bits, then clear them all
  task automatic op(logic [7:0] c, logic [7:0] m);
    swr(4'h0, c);
    for (int i = 0; i < 12; i++) begin
      srd(4'h4);
      if ((rd & m) != 8'h00) break;
    end
    swr(4'h5, 8'h07);
  endtask
  task automatic lwr(logic [7:0] a, logic [7:0] d);
    swr(4'h1, a);
    swr(4'h2, d);
    op(8'h01, 8'h03);
  endtask
  task automatic lrd(logic [7:0] a);
    swr(4'h1, a);
    op(8'h02, 8'h01);
    srd(4'h3);
  endtask
  task automatic cfg(logic [7:0] d);
    lwr(8'h58, d);
    op(8'h04, 8'h04);
  endtask
  task automatic summarize();
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial begin
    #300000;
    err_count++;
    summarize();
  end
  initial begin
    repeat (10) @(posedge ref_clk);
    rst <= 1'h0;
    foreach (rows[i]) begin
      cfg(rows[i][20:13]);
      lrd(8'h58);
      chk("readback", rd, rows[i][12:5]);
      chk("outs", {hold_outputs, detect_fine, detect_en, sync_pd, ref_pd},
        rows[i][4:0]);
    end
    $display("table done");
    ignore_sync <= 5'h01;
    cfg(8'h0C);
    chk("align set", align_lost, 1'h1);
    clr();
    cfg(8'h00);
    chk("pulses", seen, 5'h1E);
    chk("align clear", align_lost, 1'h0);
    cfg(8'h14);
    clr();
    cfg(8'h10);
    chk("blocked", seen, 5'h00);
    $display("sync done");
    func_pin <= 1'h0;
    cfg(8'h60);
    chk("pin pd", pin_pd, 1'h1);
    cfg(8'h20);
    chk("pin hold", {pin_pd, hold_outputs}, 2'h1);
    func_pin <= 1'h1;
    repeat (6) @(posedge ref_clk);
    chk("pin free", hold_outputs, 1'h0);
    clr();
    func_pin <= 1'h0;
    repeat (6) @(posedge ref_clk);
    chk("pin sync", {hold_outputs, seen}, 6'h3E);
    func_pin <= 1'h1;
    swr(4'h6, 8'h02);
    lwr(8'h58, 8'h40);
    swr(4'h1, 8'h58);
    swr(4'h0, 8'h01);
    repeat (4) @(posedge ref_clk);
    srd(4'h4);
    chk("refused", {irq, rd}, 9'h102);
    swr(4'h5, 8'h02);
    srd(4'h4);
    chk("cleared", {irq, rd}, 9'h000);
    swr(4'h6, 8'h00);
    swr(4'h0, 8'h01);
    repeat (4) @(posedge ref_clk);
    chk("masked", irq, 1'h0);
    lrd(8'h58);
    chk("kept", rd, 8'h20);
    $display("pin and refusal done");
    lwr(8'h59, 8'hFF);
    lrd(8'h59);
    chk("unused", rd, 8'h00);
    lrd(8'h5A);
    chk("update", rd, 8'h00);
    bypass_div <= 5'h15;
    delay_sel <= 1'h0;
    pll_pd_req <= 1'h1;
    out_pd_req <= 5'h0A;
    dist_pd_req <= 1'h1;
    repeat (4) @(posedge ref_clk);
    chk("div", div_pd, 5'h15);
    chk("delay", delay_pd, 1'h1);
    chk("blocks", {pll_pd, dist_pd, out_pd}, 7'h6A);
    lrd(8'h58);
    chk("retain", rd, 8'h20);
    rst <= 1'h1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'h0;
    repeat (2) @(negedge ref_clk);
    chk("no false reset", chip_reset, 1'h0);
    lrd(8'h58);
    chk("reset", {rd, ref_pd}, 9'h000);
    func_pin <= 1'h0;
    repeat (6) @(posedge ref_clk);
    chk("pin reset", chip_reset, 1'h1);
    func_pin <= 1'h1;
    repeat (6) @(posedge ref_clk);
    chk("reset free", chip_reset, 1'h0);
    $display("power and reset done");
    summarize();
  end
endmodule
`default_nettype wire
